/* File: src/chgctl_top.sv */
// charger control register and the charge behaviour it steers
//
// Summary of operation
// - with the override bit set, a safety timer expiry does not stop charging.
// - every timer expiry raises the timeout status and timer fault outputs, override or not.
// - with override clear, an expiry resets the registers and forces the idle state.
// - with recharge disable and termination set, no automatic recharge occurs.
// - with polling clear, no further absence test follows a missing battery or full charge.
// - with polling set, an absence test repeats every 2 seconds while in the no-battery or charge-done state.
// - with no battery the buck stays on and the battery switch is off.
// - charging ends on low current only when termination is enabled.
// - top-off charging happens only while top-off enable is set.
// - a one in the high-impedance request bit puts the device in high impedance.
// - while boost is enabled the high-impedance request is disregarded.
// - clearing boost with the request still set re-enters high impedance.
// - the request bit clears when battery voltage is below the minimum threshold.
// - while battery voltage is below the minimum threshold, writes to the request bit are dropped.
`timescale 1ns/100ps
module chgctl_top #(
  parameter int         POLL_PERIOD = chgctl_pkg::POLL_CYCLES,
  parameter logic [6:0] DEV_ADDR    = chgctl_pkg::DEV_ADDR_DEF
) (
  input  wire logic                   CLOCK_I,
  input  wire logic                   SRST_I,
  input  wire logic                   SCL_I,
  input  wire logic                   SDA_I,
  output logic                        SDA_O,
  output logic                        SDA_OE_O,
  input  wire chgctl_pkg::chgctl_sense_type SENSE_I,
  output chgctl_pkg::chgctl_out_type  STATUS_O,
  output logic [7:0]                  CTRL_O
);
  import chgctl_pkg::*;

  typedef struct packed {
    chgctl_sense_type sync1;
    chgctl_sense_type sync2;
    chgctl_sense_type sync3;
    logic [7:0]       ctrl;
    chgctl_state_type st;
    logic [31:0]      poll_cnt;
    chgctl_out_type   outs;
  } chgctl_reg_type;

  chgctl_reg_type   r;
  chgctl_reg_type   next_r;
  chgctl_wr_type    wr;
  logic [7:0]       ptr;
  logic [7:0]       rd_data;
  logic [7:0]       wval;
  chgctl_sense_type s;
  logic             expiry;
  logic             hz;
  logic             polling;

  function automatic logic [7:0] ctrl_read(input logic [7:0] a, input logic [7:0] c);
    if (a == CTRL_ADDR) begin
      return c & CTRL_WMASK;
    end
    return 8'h00;
  endfunction

  chgctl_i2c #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .clock_i   (CLOCK_I),
    .srst_i    (SRST_I),
    .scl_i     (SCL_I),
    .sda_i     (SDA_I),
    .sda_oe_o  (SDA_OE_O),
    .wr_o      (wr),
    .ptr_o     (ptr),
    .rd_data_i (rd_data)
  );

  // reserved bits read zero
  // masked read
  assign rd_data = ctrl_read(ptr, r.ctrl);
  assign SDA_O = 1'b0;

  always_comb begin
    next_r = r;
    wval = 8'h00;

    // sense inputs pass two flops
    next_r.sync1 = SENSE_I;
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;
    s = r.sync2;
    expiry = s.timer_expired & ~r.sync3.timer_expired;

    next_r.outs.absence_test = 1'b0;
    next_r.outs.timer_timeout_status = 1'b0;
    next_r.outs.timer_fault = 1'b0;
    next_r.outs.regs_reset = 1'b0;

    // host write of the control register
    if (wr.valid && wr.addr == CTRL_ADDR) begin
      wval = wr.data & CTRL_WMASK;
      if (s.vbat_below_min) begin
        wval[BIT_HZ] = r.ctrl[BIT_HZ];
      end
      next_r.ctrl = wval;
    end

    if (s.vbat_below_min) begin
      next_r.ctrl[BIT_HZ] = 1'b0;
    end

    hz = r.ctrl[BIT_HZ] & ~s.boost_enable;

    // absence test polling
    polling = r.ctrl[BIT_POLL] &&
              (r.st == CS_NOBAT || r.st == CS_DONE);
    if (polling) begin
      if (r.poll_cnt == 32'h0) begin
        next_r.outs.absence_test = 1'b1;
        next_r.poll_cnt = 32'(POLL_PERIOD - 1);
      end else begin
        next_r.poll_cnt = r.poll_cnt - 32'h1;
      end
    end else begin
      next_r.poll_cnt = 32'(POLL_PERIOD - 1);
    end

    case (r.st)
      CS_IDLE: begin
        if (s.source_valid && !hz) begin
          if (s.battery_present) begin
            next_r.st = CS_CHARGE;
          end else begin
            next_r.st = CS_NOBAT;
          end
        end
      end
      CS_CHARGE: begin
        if (!s.battery_present) begin
          next_r.st = CS_NOBAT;
        end else if (s.ibat_below_term && r.ctrl[BIT_TE]) begin
          if (r.ctrl[BIT_TOP]) begin
            next_r.st = CS_TOPOFF;
          end else begin
            next_r.st = CS_DONE;
          end
        end
      end
      CS_TOPOFF: begin
        if (!s.battery_present) begin
          next_r.st = CS_NOBAT;
        end else if (s.topoff_done || !r.ctrl[BIT_TOP]) begin
          next_r.st = CS_DONE;
        end
      end
      CS_DONE: begin
        if (!s.battery_present) begin
          next_r.st = CS_NOBAT;
        end else if (s.vbat_below_recharge &&
                     !(r.ctrl[BIT_RCHG] && r.ctrl[BIT_TE])) begin
          next_r.st = CS_CHARGE;
        end
      end
      CS_NOBAT: begin
        if (r.ctrl[BIT_POLL] && r.outs.absence_test &&
            s.battery_present) begin
          next_r.st = CS_CHARGE;
        end
      end
      default: begin
        next_r.st = CS_IDLE;
      end
    endcase

    if (!s.source_valid) begin
      next_r.st = CS_IDLE;
    end

    // safety timer expiry
    if (expiry) begin
      next_r.outs.timer_timeout_status = 1'b1;
      next_r.outs.timer_fault = 1'b1;
      if (!r.ctrl[BIT_OVR]) begin
        next_r.ctrl = CTRL_RESET;
        next_r.outs.regs_reset = 1'b1;
        next_r.st = CS_IDLE;
      end
    end

    // registered drive of the power stage
    next_r.outs.hz_state = hz;
    next_r.outs.idle = (next_r.st == CS_IDLE);
    next_r.outs.charge_on = !hz &&
      (next_r.st == CS_CHARGE || next_r.st == CS_TOPOFF);
    next_r.outs.buck_on = s.source_valid && !hz;
    next_r.outs.battery_switch_on = (next_r.st != CS_NOBAT) && !hz;
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      r.sync1 <= '0;
      r.sync2 <= '0;
      r.sync3 <= '0;
      r.ctrl <= CTRL_RESET;
      r.st <= CS_IDLE;
      r.poll_cnt <= 32'h0;
      r.outs <= '{idle: 1'b1, default: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign STATUS_O = r.outs;
  assign CTRL_O = r.ctrl;
endmodule // chgctl_top

/* File: src/chgctl_pkg.sv */
// shared constants and types of the charger control register block
package chgctl_pkg;
  localparam logic [7:0] CTRL_ADDR  = 8'h0e;
  localparam logic [7:0] CTRL_RESET = 8'h1c;
  localparam logic [7:0] CTRL_WMASK = 8'hbe;
  localparam int BIT_OVR  = 7;
  localparam int BIT_RCHG = 5;
  localparam int BIT_POLL = 4;
  localparam int BIT_TE   = 3;
  localparam int BIT_TOP  = 2;
  localparam int BIT_HZ   = 1;
  localparam int CLK_MHZ      = 200;
  localparam int POLL_MS      = 2000;
  localparam int POLL_CYCLES  = POLL_MS * 1000 * CLK_MHZ;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h35;
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } chgctl_wr_type;
  typedef struct packed {
    logic source_valid;
    logic battery_present;
    logic timer_expired;
    logic ibat_below_term;
    logic topoff_done;
    logic vbat_below_recharge;
    logic vbat_below_min;
    logic boost_enable;
  } chgctl_sense_type;
  typedef struct packed {
    logic charge_on;
    logic buck_on;
    logic battery_switch_on;
    logic hz_state;
    logic absence_test;
    logic idle;
    logic timer_timeout_status;
    logic timer_fault;
    logic regs_reset;
  } chgctl_out_type;
  typedef enum logic [4:0] {
    CS_IDLE   = 5'h01,
    CS_CHARGE = 5'h02,
    CS_TOPOFF = 5'h04,
    CS_DONE   = 5'h08,
    CS_NOBAT  = 5'h10
  } chgctl_state_type;
  typedef enum logic [5:0] {
    IS_IDLE = 6'h01,
    IS_ADDR = 6'h02,
    IS_ACK  = 6'h04,
    IS_WR   = 6'h08,
    IS_RD   = 6'h10,
    IS_MACK = 6'h20
  } chgctl_i2c_state_type;
endpackage

/* File: src/chgctl_i2c.sv */
// i2c slave reaching the control register, oversampled on the system clock
`timescale 1ns/100ps
module chgctl_i2c #(
  parameter logic [6:0] DEV_ADDR = chgctl_pkg::DEV_ADDR_DEF
) (
  input  wire logic                      clock_i,
  input  wire logic                      srst_i,
  input  wire logic                      scl_i,
  input  wire logic                      sda_i,
  output logic                           sda_oe_o,
  output chgctl_pkg::chgctl_wr_type      wr_o,
  output logic [7:0]                     ptr_o,
  input  wire logic [7:0]                rd_data_i
);
  import chgctl_pkg::*;
  typedef struct packed {
    logic [1:0]           scl_s;
    logic [1:0]           sda_s;
    logic                 scl_d;
    logic                 sda_d;
    chgctl_i2c_state_type st;
    logic [7:0]           sh;
    logic [3:0]           cnt;
    logic                 rw;
    logic                 first;
    logic [7:0]           ptr;
    logic                 oe;
    chgctl_wr_type        wr;
  } chgctl_i2c_reg_type;
  chgctl_i2c_reg_type r;
  chgctl_i2c_reg_type next_r;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  always_comb begin
    next_r = r;
    scl = r.scl_s[1];
    sda = r.sda_s[1];
    rise = scl & ~r.scl_d;
    fall = ~scl & r.scl_d;
    next_r.scl_s = {r.scl_s[0], scl_i};
    next_r.sda_s = {r.sda_s[0], sda_i};
    next_r.scl_d = scl;
    next_r.sda_d = sda;
    next_r.wr.valid = 1'b0;
    if (rise && r.st != IS_MACK) begin
      next_r.sh = {r.sh[6:0], sda};
      next_r.cnt = r.cnt + 4'h1;
    end
    case (r.st)
      IS_ADDR: begin
        if (fall && r.cnt == 4'h8) begin
          if (r.sh[7:1] == DEV_ADDR) begin
            next_r.rw = r.sh[0];
            next_r.oe = 1'b1;
            next_r.st = IS_ACK;
          end else begin
            next_r.st = IS_IDLE;
          end
        end
      end
      IS_ACK: begin
        if (fall) begin
          next_r.cnt = 4'h0;
          if (r.rw) begin
            next_r.sh = rd_data_i;
            next_r.oe = ~rd_data_i[7];
            next_r.st = IS_RD;
          end else begin
            next_r.oe = 1'b0;
            next_r.st = IS_WR;
          end
        end
      end
      IS_WR: begin
        if (fall && r.cnt == 4'h8) begin
          next_r.oe = 1'b1;
          next_r.st = IS_ACK;
          next_r.first = 1'b0;
          if (r.first) begin
            next_r.ptr = r.sh;
          end else begin
            next_r.wr = '{valid: 1'b1, addr: r.ptr, data: r.sh};
            next_r.ptr = r.ptr + 8'h01;
          end
        end
      end
      IS_RD: begin
        if (fall) begin
          if (r.cnt == 4'h8) begin
            next_r.oe = 1'b0;
            next_r.st = IS_MACK;
          end else begin
            next_r.oe = ~r.sh[7];
          end
        end
      end
      IS_MACK: begin
        if (rise && sda) begin
          next_r.st = IS_IDLE;
        end else if (fall) begin
          next_r.ptr = r.ptr + 8'h01;
          next_r.st = IS_ACK;
          next_r.rw = 1'b1;
        end
      end
      default: begin
        next_r.oe = 1'b0;
      end
    endcase
    if (scl && r.sda_d && !sda) begin
      next_r.st = IS_ADDR;
      next_r.cnt = 4'h0;
      next_r.first = 1'b1;
      next_r.oe = 1'b0;
    end else if (scl && !r.sda_d && sda) begin
      next_r.st = IS_IDLE;
      next_r.oe = 1'b0;
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      r <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1, st: IS_IDLE,
             sh: 8'h00, cnt: 4'h0, rw: 1'b0, first: 1'b0, ptr: 8'h00, oe: 1'b0,
             wr: '0};
    end else begin
      r <= next_r;
    end
  end
  assign sda_oe_o = r.oe;
  assign wr_o = r.wr;
  assign ptr_o = r.ptr;
endmodule // chgctl_i2c

/* File: tb/chgctl_monitor.sv */
// port assertions of the charger control block
`timescale 1ns/100ps
module chgctl_monitor (
  input wire logic                         CLOCK_I,
  input wire logic                         SRST_I,
  input wire chgctl_pkg::chgctl_sense_type SENSE_I,
  input wire chgctl_pkg::chgctl_out_type   STATUS_O,
  input wire logic [7:0]                   CTRL_O
);
  import chgctl_pkg::*;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  sequence expiry_s;
    $rose(SENSE_I.timer_expired);
  endsequence
  sequence flag_s;
    ##[3:4] (STATUS_O.timer_timeout_status && STATUS_O.timer_fault);
  endsequence
  sequence reset_s;
    ##[3:4] STATUS_O.regs_reset ##1 CTRL_O == CTRL_RESET;
  endsequence
  sequence keep_s;
    flag_s ##0 !STATUS_O.regs_reset ##1 CTRL_O[7];
  endsequence
  hz_enter_a: assert property ((CTRL_O[1] && !SENSE_I.boost_enable)[*5] |-> STATUS_O.hz_state)
    else $error("hz state missing");
  hz_boost_a: assert property (SENSE_I.boost_enable[*5] |-> !STATUS_O.hz_state)
    else $error("hz during boost");
  lowbat_clear_a: assert property (SENSE_I.vbat_below_min[*5] |-> !CTRL_O[1])
    else $error("hz request kept at low battery");
  reserved_zero_a: assert property (CTRL_O[6] == 1'b0 && CTRL_O[0] == 1'b0)
    else $error("reserved bit set");
  expiry_flag_a: assert property (expiry_s |-> flag_s)
    else $error("expiry flags missing");
  expiry_reset_a: assert property (expiry_s ##0 !CTRL_O[7] |-> reset_s)
    else $error("no register reset on expiry");
  override_keep_a: assert property (expiry_s ##0 CTRL_O[7] |-> keep_s)
    else $error("override lost on expiry");
  poll_off_a: assert property ((!CTRL_O[4])[*5] |-> !STATUS_O.absence_test)
    else $error("absence test without polling");
  nobat_power_a: assert property ((SENSE_I.source_valid && !SENSE_I.battery_present &&
    !STATUS_O.hz_state && !STATUS_O.idle)[*5] |-> STATUS_O.buck_on && !STATUS_O.battery_switch_on)
    else $error("power path wrong without battery");
endmodule // chgctl_monitor
bind chgctl_top chgctl_monitor chgctl_monitor_inst (.CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .SENSE_I(SENSE_I),
  .STATUS_O(STATUS_O), .CTRL_O(CTRL_O));

/* File: tb/chgctl_host_model.sv */
// i2c host model driving the register pins
`timescale 1ns/100ps
module chgctl_host_model (
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  import chgctl_pkg::*;
  logic lclk = 1'b0;
  always #40 lclk = ~lclk;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic step(input logic s, input logic d, output logic r);
    @(posedge lclk);
    r = sda_i;
    scl_o = s;
    sda_low_o = d;
  endtask
  task automatic start;
    logic x;
    step(scl_o, 1'b0, x);
    step(1'b1, 1'b0, x);
    step(1'b1, 1'b1, x);
    step(1'b0, 1'b1, x);
  endtask
  task automatic stop;
    logic x;
    step(1'b0, 1'b1, x);
    step(1'b1, 1'b1, x);
    step(1'b1, 1'b0, x);
  endtask
  task automatic byte_x(input logic [8:0] d, output logic [8:0] q);
    logic x;
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, ~d[i], x);
      step(1'b1, ~d[i], x);
      step(1'b0, ~d[i], q[i]);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
    logic [8:0] q;
    start;
    byte_x({a, 2'h1}, q);
    byte_x({p, 1'b1}, q);
    byte_x({d, 1'b1}, q);
    stop;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] v);
    logic [8:0] q;
    start;
    byte_x({DEV_ADDR_DEF, 2'h1}, q);
    byte_x({p, 1'b1}, q);
    start;
    byte_x({DEV_ADDR_DEF, 2'h3}, q);
    byte_x(9'h1ff, q);
    stop;
    v = q[8:1];
  endtask
endmodule // chgctl_host_model

/* File: tb/tb_top.sv */
// self-checking bench of the charger control block
`timescale 1ns/100ps
module tb_top;
  import chgctl_pkg::*;
  logic             clock = 1'b0;
  logic             srst = 1'b1;
  logic             scl, sda_low, sda_oe, sda_o, sda_w;
  chgctl_sense_type sense = '0;
  chgctl_out_type   status;
  logic [7:0]       ctrl;
  int               err_count = 0;
  int               checks = 0;
  int               na, nf, nr, ni;
  always #2.5 clock = ~clock;
  assign sda_w = ~(sda_oe | sda_low);
  chgctl_host_model chgctl_host_model_inst (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w));
  chgctl_top #(.POLL_PERIOD(50)) chgctl_top_inst (.CLOCK_I(clock), .SRST_I(srst), .SCL_I(scl),
    .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .SENSE_I(sense), .STATUS_O(status), .CTRL_O(ctrl));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    chgctl_host_model_inst.wr(DEV_ADDR_DEF, p, d);
    tick(2);
  endtask
  task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] v;
    chgctl_host_model_inst.rd(p, v);
    chk(v, e);
    tick(2);
  endtask
  task automatic count(input int c);
    na = 0;
    nf = 0;
    nr = 0;
    ni = 0;
    repeat (c) begin
      tick(1);
      na += status.absence_test;
      nf += status.timer_fault & status.timer_timeout_status;
      nr += status.regs_reset;
      ni += status.idle;
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    err_count++;
    final_report;
  end
  initial begin
    tick(3);
    srst = 1'b0;
    tick(4);
    chk(ctrl, CTRL_RESET);
    chk(8'(sda_o), 8'h00);
    rd_chk(CTRL_ADDR, 8'h1c);
    chgctl_host_model_inst.wr(DEV_ADDR_DEF ^ 7'h01, CTRL_ADDR, 8'h00);
    tick(2);
    chk(ctrl, CTRL_RESET);
    wr(CTRL_ADDR, 8'hff);
    rd_chk(CTRL_ADDR, CTRL_WMASK);
    chk(8'(status.hz_state), 8'h01);
    sense.boost_enable = 1'b1;
    tick(6);
    chk(8'(status.hz_state), 8'h00);
    sense.boost_enable = 1'b0;
    tick(6);
    chk(8'(status.hz_state), 8'h01);
    wr(8'h0f, 8'hff);
    rd_chk(8'h0f, 8'h00);
    sense.vbat_below_min = 1'b1;
    tick(6);
    chk(8'(ctrl[1]), 8'h00);
    wr(CTRL_ADDR, 8'h1e);
    chk(ctrl, 8'h1c);
    sense.vbat_below_min = 1'b0;
    $display("test register and hz done");
    sense.source_valid = 1'b1;
    sense.battery_present = 1'b1;
    wr(CTRL_ADDR, 8'h14);
    sense.ibat_below_term = 1'b1;
    tick(20);
    chk(8'(status.charge_on), 8'h01);
    wr(CTRL_ADDR, 8'h38);
    chk(8'(status.charge_on), 8'h00);
    sense.vbat_below_recharge = 1'b1;
    tick(20);
    chk(8'(status.charge_on), 8'h00);
    sense.ibat_below_term = 1'b0;
    wr(CTRL_ADDR, 8'h9c);
    tick(10);
    chk(8'(status.charge_on), 8'h01);
    $display("test charge control done");
    sense.timer_expired = 1'b1;
    count(8);
    chk(8'(nf), 8'h01);
    chk(8'(nr), 8'h00);
    chk(8'(status.charge_on), 8'h01);
    chk(ctrl, 8'h9c);
    sense.timer_expired = 1'b0;
    wr(CTRL_ADDR, 8'h3c);
    sense.timer_expired = 1'b1;
    count(8);
    chk(8'(nf), 8'h01);
    chk(8'(nr), 8'h01);
    chk(8'(ni > 0), 8'h01);
    chk(ctrl, 8'h1c);
    sense.timer_expired = 1'b0;
    sense.vbat_below_recharge = 1'b0;
    sense.ibat_below_term = 1'b1;
    tick(10);
    chk(8'(status.charge_on), 8'h01);
    sense.topoff_done = 1'b1;
    tick(10);
    chk(8'(status.charge_on), 8'h00);
    sense.ibat_below_term = 1'b0;
    sense.topoff_done = 1'b0;
    $display("test safety timer done");
    sense.source_valid = 1'b0;
    sense.battery_present = 1'b0;
    tick(6);
    sense.source_valid = 1'b1;
    count(210);
    chk(8'(na >= 3 && na <= 5), 8'h01);
    chk(8'(status.buck_on), 8'h01);
    chk(8'(status.battery_switch_on), 8'h00);
    wr(CTRL_ADDR, 8'h0c);
    count(210);
    chk(8'(na), 8'h00);
    $display("test no battery done");
    final_report;
  end
endmodule // tb_top
